// *** dac_power_ctrl.sv ***
// Purpose: power-up, reference and fault-status logic of a quad converter
// Assumes: serial framing done elsewhere; one-cycle strobe per decoded 24-bit word
// Notes: fault inputs arrive from analog sense circuits and are synchronised here
// Notes: the readback image is registered, so it trails the controls by one edge
// Notes: the host settle time after a power-up is the host's duty, not policed here
`timescale 1ns/1ps

// three-flop synchroniser with an agreement filter for asynchronous fault levels;
// a change is accepted only once stages two and three agree, so a sense glitch
// shorter than one cycle never reaches the power-down logic
module fault_level_filter
	import dac_power_pkg::*;
#(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// asynchronous level in, filtered level out
	input wire logic [WIDTH-1:0] level_async,
	output logic [WIDTH-1:0] level_ff
);
	logic [WIDTH-1:0] sync_s1_ff;
	logic [WIDTH-1:0] sync_s2_ff;
	logic [WIDTH-1:0] sync_s3_ff;

	// only the second stage reads the first, so a metastable value goes nowhere else
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_s1_ff <= '0;
			sync_s2_ff <= '0;
			sync_s3_ff <= '0;
		end else begin
			sync_s1_ff <= level_async;
			sync_s2_ff <= sync_s1_ff;
			sync_s3_ff <= sync_s2_ff;
		end
	end

	// per bit: keep the last accepted level while the late stages disagree
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			level_ff <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (sync_s2_ff[i] == sync_s3_ff[i])
					level_ff[i] <= sync_s3_ff[i];
			end
		end
	end
endmodule // fault_level_filter

// one channel's power-up bit: host write, unclamped overcurrent and thermal shutdown
module chan_power_slice
	import dac_power_pkg::*;
#(
	parameter logic RESET_VALUE = 1'b0
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// host write of this channel's bit
	input wire logic bit_write,
	input wire logic bit_value,
	// fault power-down requests
	input wire logic oc_trip,
	input wire logic thermal_trip,
	// power-up state
	output logic power_on_ff
);
	logic nxt_power_on;

	// a fault power-down beats a write in the same cycle,
	// so a channel is never re-enabled into a live short while clamping is off
	always_comb begin
		nxt_power_on = power_on_ff;
		if (bit_write)
			nxt_power_on = bit_value;
		if (oc_trip)
			nxt_power_on = 1'b0;
		if (thermal_trip)
			nxt_power_on = 1'b0;
	end

	// reset leaves the channel powered down until the host sets its bit
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			power_on_ff <= RESET_VALUE;
		else
			power_on_ff <= nxt_power_on;
	end
endmodule // chan_power_slice

module dac_power_ctrl
	import dac_power_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// decoded serial command
	input wire logic cmd_valid,
	input wire logic [23:0] cmd_word,
	// readback of the power register
	output logic [DATA_W-1:0] power_and_alert_status,
	// analog fault sense, asynchronous
	input wire logic [NUM_CHAN-1:0] overcurrent_sense,
	input wire logic overtemp_sense,
	// analog controls
	output logic [NUM_CHAN-1:0] chan_power_on,
	output logic reference_power_on,
	output logic clamp_enable,
	output logic thermal_shutdown_alert
);
	logic [NUM_CHAN-1:0] oc_flag_ff;
	logic ot_ff;
	logic [NUM_CHAN-1:0] pu_ff;
	logic ref_ff, clamp_ff, tsd_en_ff, tsd_alert_ff;
	logic rw_read, pwr_write, cfg_write, thermal_trip;
	logic [NUM_CHAN-1:0] oc_trip;
	logic [2:0] reg_sel;
	logic [2:0] reg_addr;
	logic [DATA_W-1:0] nxt_status;

	// command fields; the address only matters for the control register
	assign reg_sel = cmd_word[CMD_REG_HI:CMD_REG_LO];
	assign reg_addr = cmd_word[CMD_ADDR_HI:CMD_ADDR_LO];
	// write when the read/write bit is low; reads leave every setting alone
	assign rw_read = cmd_word[CMD_RW_BIT];
	assign pwr_write = cmd_valid && !rw_read && reg_sel == REG_SEL_POWER;
	assign cfg_write = cmd_valid && !rw_read && reg_sel == REG_SEL_CONTROL
		&& reg_addr == CTRL_ADDR_CONFIG;

	// per-channel overcurrent levels; flags follow the sense, so they drop
	// again by themselves once the short is gone
	fault_level_filter #(
		.WIDTH(NUM_CHAN)
	) u_fault_level_filter_oc (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.level_async(overcurrent_sense),
		.level_ff(oc_flag_ff)
	);

	// die temperature level, same filtering as the overcurrent path
	fault_level_filter #(
		.WIDTH(1)
	) u_fault_level_filter_ot (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.level_async(overtemp_sense),
		.level_ff(ot_ff)
	);

	// clamping keeps the channel alive; only unclamped overcurrent trips it
	assign oc_trip = clamp_ff ? '0 : oc_flag_ff;
	assign thermal_trip = tsd_en_ff && ot_ff;

	// control register config bits that steer fault handling
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			clamp_ff <= CLAMP_EN_RESET;
			tsd_en_ff <= TSD_EN_RESET;
		end else if (cfg_write) begin
			clamp_ff <= cmd_word[CFG_CLAMP_EN_BIT];
			tsd_en_ff <= cmd_word[CFG_TSD_EN_BIT];
		end
	end

	// one power-up slice per channel; channel A sits at the lowest bit
	for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
		chan_power_slice #(
			.RESET_VALUE(PU_RESET[ch])
		) u_chan_power_slice (
			.ref_clk(ref_clk),
			.rst_n(rst_n),
			.bit_write(pwr_write),
			.bit_value(cmd_word[PWR_PU_LO + ch]),
			.oc_trip(oc_trip[ch]),
			.thermal_trip(thermal_trip),
			.power_on_ff(pu_ff[ch])
		);
	end

	// reference enable
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			ref_ff <= REF_RESET;
		else if (pwr_write)
			ref_ff <= cmd_word[PWR_REF_BIT];
	end

	// thermal alert is read-only and sticky while the shutdown stands
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			tsd_alert_ff <= 1'b0;
		else if (thermal_trip)
			tsd_alert_ff <= 1'b1;
		else if (!ot_ff)
			tsd_alert_ff <= 1'b0;
	end

	// readback image built field by field; written alert and zero bits never land here
	always_comb begin
		nxt_status = '0;
		nxt_status[PWR_OC_HI:PWR_OC_LO] = oc_flag_ff;
		nxt_status[PWR_ZERO_BIT] = 1'b0;
		nxt_status[PWR_TSD_BIT] = tsd_alert_ff;
		nxt_status[PWR_REF_BIT] = ref_ff;
		nxt_status[PWR_PU_HI:PWR_PU_LO] = pu_ff;
	end

	// registered so the host sees a settled word, one edge behind the controls
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			power_and_alert_status <= '0;
		else
			power_and_alert_status <= nxt_status;
	end

	// controls to the analog side come straight from flip-flops
	assign chan_power_on = pu_ff;
	assign reference_power_on = ref_ff;
	assign clamp_enable = clamp_ff;
	assign thermal_shutdown_alert = tsd_alert_ff;
	// host must still wait POWER_UP_CYCLES before loading outputs; not policed here
endmodule // dac_power_ctrl

// *** dac_power_pkg.sv ***
// Purpose: constants for the quad converter power and fault-status control block
// Assumes: register reached over a decoded serial command word (24 bits)
// Notes: register layout, select codes and timing figures
package dac_power_pkg;
	localparam int unsigned NUM_CHAN = 4;
	localparam int unsigned DATA_W = 16;
	// command word layout
	localparam int unsigned CMD_RW_BIT = 23;
	localparam int unsigned CMD_REG_HI = 21;
	localparam int unsigned CMD_REG_LO = 19;
	localparam int unsigned CMD_ADDR_HI = 18;
	localparam int unsigned CMD_ADDR_LO = 16;
	localparam logic [2:0] REG_SEL_POWER = 3'h2;
	localparam logic [2:0] REG_SEL_CONTROL = 3'h3;
	localparam logic [2:0] CTRL_ADDR_CONFIG = 3'h1;
	// control register config bits
	localparam int unsigned CFG_TSD_EN_BIT = 3;
	localparam int unsigned CFG_CLAMP_EN_BIT = 2;
	localparam logic CLAMP_EN_RESET = 1'b1;
	localparam logic TSD_EN_RESET = 1'b0;
	// power register fields
	localparam int unsigned PWR_OC_LO = 7;
	localparam int unsigned PWR_OC_HI = 10;
	localparam int unsigned PWR_ZERO_BIT = 6;
	localparam int unsigned PWR_TSD_BIT = 5;
	localparam int unsigned PWR_REF_BIT = 4;
	localparam int unsigned PWR_PU_HI = 3;
	localparam int unsigned PWR_PU_LO = 0;
	localparam logic [3:0] PU_RESET = 4'h0;
	localparam logic REF_RESET = 1'b0;
	// host-side settle time after power-up
	localparam int unsigned POWER_UP_US = 10;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned POWER_UP_CYCLES = POWER_UP_US * CLK_MHZ;
endpackage

// *** dac_power_host.sv ***
// Purpose: host model issuing command words
// Assumes: one word per call, strobe lasts one cycle
// Notes: waits the settle time after any channel power-up
`timescale 1ns/1ps
module dac_power_host
	import dac_power_pkg::*;
(
	// clock and command
	input wire logic ref_clk,
	output logic cmd_valid,
	output logic [23:0] cmd_word
);
	initial cmd_valid = 1'b0;
	initial cmd_word = 24'h000000;
	// word is inverted once the strobe drops so stale data is never trusted
	task automatic send(input logic [23:0] w);
		@(posedge ref_clk) #1;
		cmd_word = w;
		cmd_valid = 1'b1;
		@(posedge ref_clk) #1;
		cmd_valid = 1'b0;
		cmd_word = ~w;
		if (w[23:19] == 5'h02 && w[3:0] != 4'h0) begin
			repeat (POWER_UP_CYCLES) @(posedge ref_clk);
			#1;
		end
	endtask
endmodule // dac_power_host

// *** dac_power_ctrl_checker.sv ***
// Purpose: port assertions for power and alert control
// Assumes: sense inputs held steady around checks
// Notes: bound to each instance
`timescale 1ns/1ps
module dac_power_ctrl_checker
	import dac_power_pkg::*;
(
	// clock, reset, command and sense
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cmd_valid,
	input wire logic [23:0] cmd_word,
	input wire logic [NUM_CHAN-1:0] overcurrent_sense,
	// block outputs
	input wire logic [DATA_W-1:0] power_and_alert_status,
	input wire logic [NUM_CHAN-1:0] chan_power_on,
	input wire logic reference_power_on,
	input wire logic clamp_enable
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// decoded writes; reads never count
	wire wp = cmd_valid && !cmd_word[23] && cmd_word[21:19] == REG_SEL_POWER;
	wire wc = cmd_valid && !cmd_word[23] && cmd_word[21:16] == 6'h19;
	wire [3:0] oc = power_and_alert_status[10:7];
	property p_ref; wp |=> reference_power_on == $past(cmd_word[4]); endproperty
	a_ref: assert property (p_ref) else $error("ref");
	property p_refh; !wp |=> $stable(reference_power_on); endproperty
	a_refh: assert property (p_refh) else $error("ref moved");
	property p_rb; power_and_alert_status[4] == $past(reference_power_on); endproperty
	a_rb: assert property (p_rb) else $error("ref readback");
	property p_zero; power_and_alert_status[15:11] == 5'h00 && !power_and_alert_status[6]; endproperty
	a_zero: assert property (p_zero) else $error("zero bits");
	property p_rise; !wp |=> (chan_power_on & ~$past(chan_power_on)) == 4'h0; endproperty
	a_rise: assert property (p_rise) else $error("power rose");
	property p_oc; $stable(overcurrent_sense) [*6] |-> oc == overcurrent_sense; endproperty
	a_oc: assert property (p_oc) else $error("oc flag");
	property p_pd; !clamp_enable && !$past(clamp_enable) |-> (chan_power_on & oc) == 4'h0; endproperty
	a_pd: assert property (p_pd) else $error("oc power");
	property p_clh; !wc |=> $stable(clamp_enable); endproperty
	a_clh: assert property (p_clh) else $error("clamp moved");
	// main scenarios
	c_wr: cover property (wp);
	c_pd: cover property (!clamp_enable && oc != 4'h0);
	c_cl: cover property (clamp_enable && oc != 4'h0);
endmodule // dac_power_ctrl_checker
bind dac_power_ctrl dac_power_ctrl_checker u_dac_power_ctrl_checker (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.cmd_valid(cmd_valid),
	.cmd_word(cmd_word),
	.overcurrent_sense(overcurrent_sense),
	.power_and_alert_status(power_and_alert_status),
	.chan_power_on(chan_power_on),
	.reference_power_on(reference_power_on),
	.clamp_enable(clamp_enable)
);

// *** test_dac_power_ctrl.sv ***
// Purpose: self-checking bench for power and alert control
// Assumes: fault sense held past the synchroniser
// Notes: readback compared through an expectation queue
`timescale 1ns/1ps
`define CMP(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
	$display("CHECK FAILED %0t got %h exp %h", $time, a, e); end end
module test_dac_power_ctrl;
	import dac_power_pkg::*;
	logic ref_clk, rst_n, cmd_valid, overtemp_sense, reference_power_on;
	logic clamp_enable, thermal_shutdown_alert;
	logic [23:0] cmd_word;
	logic [3:0] overcurrent_sense, chan_power_on;
	logic [15:0] power_and_alert_status, r, e;
	logic [15:0] exp_q[$];
	int mismatches = 0, n_checks = 0, cyc = 0;
	event chk;
	dac_power_host u_dac_power_host (.*);
	dac_power_ctrl u_dac_power_ctrl (.*);
	// clock, and a cycle ceiling so a hang still reports
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			finish_test();
		end
	end
	// monitor takes the oldest note when a result is due
	always @(chk) begin
		e = exp_q.pop_front();
		`CMP(power_and_alert_status, e)
		`CMP(chan_power_on, e[3:0])
		`CMP(reference_power_on, e[4])
		`CMP(thermal_shutdown_alert, e[5])
	end
	task automatic tx(input logic [23:0] w);
		u_dac_power_host.send(w);
	endtask
	// readback settles two edges after the write
	task automatic note(input logic [15:0] v);
		repeat (2) @(posedge ref_clk);
		#1;
		exp_q.push_back(v);
		->chk;
	endtask
	task automatic wt(input logic [3:0] oc, input logic ot);
		overcurrent_sense = oc;
		overtemp_sense = ot;
		repeat (8) @(posedge ref_clk);
		#1;
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		rst_n = 1'b0;
		overcurrent_sense = 4'h0;
		overtemp_sense = 1'b0;
		void'($urandom(32'h61b3));
		repeat (4) @(posedge ref_clk);
		#1;
		rst_n = 1'b1;
		note(16'h0000);
		`CMP(clamp_enable, 1'b1)
		r = $urandom;
		tx({8'h10, r[15:5], 5'h1f});
		tx(24'h900000);
		tx(24'h180000);
		note(16'h001f);
		repeat (4) begin
			r = $urandom;
			tx({8'h10, r});
			note({11'h000, r[4:0]});
		end
		$display("write test done");
		tx(24'h10000f);
		wt(4'ha, 1'b0);
		note(16'h050f);
		wt(4'h0, 1'b0);
		note(16'h000f);
		tx(24'h190000);
		wt(4'h5, 1'b0);
		note(16'h028a);
		wt(4'h0, 1'b1);
		`CMP(power_and_alert_status[3:0], 4'ha)
		wt(4'h0, 1'b0);
		tx(24'h190008);
		tx(24'h10000f);
		wt(4'h0, 1'b1);
		note(16'h0020);
		$display("fault test done");
		// mid-run reset with the overtemperature still present
		rst_n = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		rst_n = 1'b1;
		wt(4'h0, 1'b1);
		note(16'h0000);
		`CMP(clamp_enable, 1'b1)
		$display("reset test done");
		finish_test();
	end
endmodule // test_dac_power_ctrl
